//--- pkg/osc_pkg.sv
// osc_pkg: constants, register map and types of the operating state controller
// assumes one 200 MHz clock and a plain word-wide register port
package osc_pkg;

  // ==========================================================
  // clock and timing
  localparam longint CLK_HZ         = 200_000_000;
  localparam longint LONG_PRESS_S   = 5;
  localparam longint SUPPRESS_S     = 15;
  localparam longint DEBOUNCE_MS    = 10;
  localparam longint INIT_MS        = 2000;
  localparam longint BEEP_MS        = 100;
  localparam longint SEC_CYC        = CLK_HZ;
  localparam longint LONG_PRESS_CYC = LONG_PRESS_S * CLK_HZ;
  localparam longint DEBOUNCE_CYC   = (DEBOUNCE_MS * CLK_HZ) / 1000;
  localparam longint INIT_CYC       = (INIT_MS * CLK_HZ) / 1000;
  localparam longint BEEP_CYC       = (BEEP_MS * CLK_HZ) / 1000;
  // one spare second so the hold-off never runs short of its full time
  localparam logic [4:0] SUPPRESS_LOAD = 5'(SUPPRESS_S + 1);

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DELAY  = 8'h04;
  localparam logic [7:0] OFS_FBTIME = 8'h08;
  localparam logic [7:0] OFS_START  = 8'h0c;
  localparam logic [7:0] OFS_END    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ==========================================================
  // control register fields
  localparam int CTRL_WAKE_BTN  = 0;
  localparam int CTRL_WAKE_PIN  = 1;
  localparam int CTRL_WAKE_TIME = 2;
  localparam int CTRL_WAKE_NET  = 3;
  localparam int CTRL_SD_BTN    = 4;
  localparam int CTRL_SD_PIN    = 5;
  localparam int CTRL_SD_TIME   = 6;
  localparam int CTRL_SD_AUTO   = 7;
  localparam int CTRL_SD_TIMER  = 8;
  localparam int CTRL_SLEEP_FBS = 9;
  localparam int CTRL_AFTER_LSB = 10;

  // ==========================================================
  // reset values
  localparam logic [11:0] CTRL_RST   = 12'h1ff;
  localparam logic [15:0] DELAY_RST  = 16'h0000;
  localparam logic [15:0] FBTIME_RST = 16'h0e10;
  localparam logic [31:0] TIME_RST   = 32'hffff_ffff;

  // after-measurement choice
  localparam logic [1:0] AFTER_STAY = 2'h0;
  localparam logic [1:0] AFTER_FBS  = 2'h1;

  // ==========================================================
  // types
  typedef enum logic [1:0] {OP_OFF, OP_LPS, OP_FBS, OP_ON} osc_op_e;

  typedef struct packed {
    logic pc_on;
    logic if_on;
    logic rec_ready;
    logic wake_armed;
    logic sleep_armed;
  } osc_pwr_s;

endpackage : osc_pkg

//--- design/osc_ctrl.sv
// osc_ctrl: power operating state controller with its register file
// assumes button and pin inputs are asynchronous, time and handshakes are on clock
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps

module osc_ctrl
  import osc_pkg::*;
#(
  parameter logic [31:0] SEC_CYCLES   = 32'(SEC_CYC),
  parameter logic [31:0] LONG_CYCLES  = 32'(LONG_PRESS_CYC),
  parameter logic [31:0] DEB_CYCLES   = 32'(DEBOUNCE_CYC),
  parameter logic [31:0] INIT_CYCLES  = 32'(INIT_CYC),
  parameter logic [31:0] BEEP_CYCLES  = 32'(BEEP_CYC)
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        supply_present,
  input  wire logic        button_n,
  input  wire logic        remote_button_input_n,
  input  wire logic        remote_power_state_input,
  input  wire logic        network_activity_wake,
  input  wire logic [31:0] current_time,
  input  wire logic        meas_done,
  input  wire logic        tasks_pending,
  input  wire logic        exp_shutdown,
  input  wire logic        recording_busy,
  input  wire logic        transfer_busy,
  input  wire logic        hib_done,
  output osc_op_e          op_state,
  output osc_pwr_s         pwr,
  output logic             meas_start,
  output logic             meas_stop,
  output logic             hib_save_req,
  output logic             ack_beep,
  output logic             emergency_off
);

  typedef enum {
    S_OFF, S_INIT, S_SAVE, S_LPS, S_FBS, S_ON, S_STOP, S_WREC, S_WXFER
  } osc_st_e;

  // ==========================================================
  // registers
  logic [11:0] ctrl_q;
  logic [15:0] delay_q;
  logic [15:0] fbtime_q;
  logic [31:0] start_q;
  logic [31:0] end_q;
  logic [31:0] rdata_q;
  logic [31:0] status_w;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_q   <= CTRL_RST;
      delay_q  <= DELAY_RST;
      fbtime_q <= FBTIME_RST;
      start_q  <= TIME_RST;
      end_q    <= TIME_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CTRL) begin
        ctrl_q <= reg_wdata[11:0];
      end else if (reg_addr == OFS_DELAY) begin
        delay_q <= reg_wdata[15:0];
      end else if (reg_addr == OFS_FBTIME) begin
        fbtime_q <= reg_wdata[15:0];
      end else if (reg_addr == OFS_START) begin
        start_q <= reg_wdata;
      end else if (reg_addr == OFS_END) begin
        end_q <= reg_wdata;
      end
    end
  end

  // read data stands for one cycle only, unmapped reads give zero
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (!reg_rd) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_addr == OFS_CTRL) begin
      rdata_q <= {20'h00000, ctrl_q};
    end else if (reg_addr == OFS_DELAY) begin
      rdata_q <= {16'h0000, delay_q};
    end else if (reg_addr == OFS_FBTIME) begin
      rdata_q <= {16'h0000, fbtime_q};
    end else if (reg_addr == OFS_START) begin
      rdata_q <= start_q;
    end else if (reg_addr == OFS_END) begin
      rdata_q <= end_q;
    end else if (reg_addr == OFS_STATUS) begin
      rdata_q <= status_w;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // input synchronisers
  logic [4:0] sy1_q;
  logic [4:0] sy2_q;
  logic       pin_q;
  logic       net_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sy1_q <= 5'h00;
      sy2_q <= 5'h00;
      pin_q <= 1'b0;
      net_q <= 1'b0;
    end else begin
      sy1_q <= {supply_present, network_activity_wake, remote_power_state_input,
                ~remote_button_input_n, ~button_n};
      sy2_q <= sy1_q;
      pin_q <= sy2_q[2];
      net_q <= sy2_q[3];
    end
  end

  logic supply_w;
  logic pin_rise;
  logic pin_fall;
  logic net_rise;
  assign supply_w = sy2_q[4];
  assign pin_rise = sy2_q[2] & ~pin_q;
  assign pin_fall = ~sy2_q[2] & pin_q;
  assign net_rise = sy2_q[3] & ~net_q;

  // ==========================================================
  // button debounce and press timing, either button acts the same
  logic        btn_db_q;
  logic [31:0] deb_cnt_q;
  logic [31:0] press_cnt_q;
  logic        btn_short;
  logic        btn_long;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      btn_db_q  <= 1'b0;
      deb_cnt_q <= 32'h0000_0000;
    end else if ((sy2_q[0] | sy2_q[1]) == btn_db_q) begin
      deb_cnt_q <= 32'h0000_0000;
    end else if (deb_cnt_q >= DEB_CYCLES - 32'h1) begin
      btn_db_q  <= ~btn_db_q;
      deb_cnt_q <= 32'h0000_0000;
    end else begin
      deb_cnt_q <= deb_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      press_cnt_q <= 32'h0000_0000;
    end else if (!btn_db_q) begin
      press_cnt_q <= 32'h0000_0000;
    end else if (press_cnt_q != LONG_CYCLES) begin
      press_cnt_q <= press_cnt_q + 32'h1;
    end
  end

  // release before the limit is short; the long event fires once while held
  assign btn_short = deb_cnt_q >= DEB_CYCLES - 32'h1 && btn_db_q &&
                     (sy2_q[0] | sy2_q[1]) == 1'b0 && press_cnt_q < LONG_CYCLES;
  assign btn_long  = btn_db_q && press_cnt_q == LONG_CYCLES - 32'h1;

  // ==========================================================
  // calendar match and second tick
  logic        start_hit_q;
  logic        end_hit_q;
  logic [31:0] sec_cnt_q;
  logic        tick_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      start_hit_q <= 1'b0;
      end_hit_q   <= 1'b0;
    end else begin
      start_hit_q <= current_time == start_q;
      end_hit_q   <= current_time == end_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sec_cnt_q <= 32'h0000_0000;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= sec_cnt_q == SEC_CYCLES - 32'h1;
      if (sec_cnt_q == SEC_CYCLES - 32'h1) begin
        sec_cnt_q <= 32'h0000_0000;
      end else begin
        sec_cnt_q <= sec_cnt_q + 32'h1;
      end
    end
  end

  logic start_ev;
  logic end_ev;
  assign start_ev = (current_time == start_q) & ~start_hit_q;
  assign end_ev   = (current_time == end_q) & ~end_hit_q;

  // ==========================================================
  // event qualification
  osc_st_e     st_q;
  osc_st_e     st_d;
  logic [4:0]  sup_cnt_q;
  logic        pend_q;
  logic        pend_wake_q;
  logic        pend_lps_q;
  logic [15:0] pend_cnt_q;
  logic [15:0] fb_cnt_q;
  logic        fb_run_q;

  logic standby;
  logic on_st;
  logic muted;
  logic btn_wake;
  logic btn_sd;
  logic emerg;
  logic oth_wake;
  logic oth_sd;
  logic auto_ev;
  logic exp_ev;
  logic fb_exp;
  logic pend_fire;
  logic sleep_lps;

  assign standby   = st_q == S_LPS || st_q == S_FBS;
  assign on_st     = st_q == S_ON;
  assign muted     = sup_cnt_q != 5'h00;
  assign sleep_lps = ~ctrl_q[CTRL_SLEEP_FBS];
  assign btn_wake  = btn_short & ctrl_q[CTRL_WAKE_BTN] & standby;
  assign btn_sd    = btn_short & ctrl_q[CTRL_SD_BTN] & on_st;
  assign emerg     = btn_long & ctrl_q[CTRL_SD_BTN] & on_st;
  assign oth_wake  = standby & ~muted &
                     ((pin_rise & ctrl_q[CTRL_WAKE_PIN]) |
                      (start_ev & ctrl_q[CTRL_WAKE_TIME]) |
                      (net_rise & ctrl_q[CTRL_WAKE_NET]));
  assign oth_sd    = on_st & ~muted &
                     ((pin_fall & ctrl_q[CTRL_SD_PIN]) |
                      (end_ev & ctrl_q[CTRL_SD_TIME]));
  // a finished measurement with nothing left to do leaves on, per choice
  assign auto_ev   = on_st & meas_done & ~tasks_pending & ctrl_q[CTRL_SD_AUTO] &
                     ctrl_q[CTRL_AFTER_LSB +: 2] != AFTER_STAY;
  assign exp_ev    = on_st & exp_shutdown & ctrl_q[CTRL_SD_AUTO];
  assign fb_exp    = st_q == S_FBS & fb_run_q & fb_cnt_q == 16'h0000 &
                     ctrl_q[CTRL_SD_TIMER];
  assign pend_fire = pend_q & pend_cnt_q == 16'h0000;

  // delayed events: first one in holds the slot until it fires or the state changes
  always_ff @(posedge clock) begin
    if (!nrst || st_q == S_OFF) begin
      pend_q      <= 1'b0;
      pend_wake_q <= 1'b0;
      pend_lps_q  <= 1'b0;
      pend_cnt_q  <= 16'h0000;
    end else if (pend_fire || st_d != st_q) begin
      pend_q <= 1'b0;
    end else if (!pend_q && (oth_wake || oth_sd || auto_ev || fb_exp)) begin
      pend_q      <= 1'b1;
      pend_wake_q <= oth_wake;
      pend_lps_q  <= fb_exp | (auto_ev ? ctrl_q[CTRL_AFTER_LSB +: 2] != AFTER_FBS : sleep_lps);
      pend_cnt_q  <= delay_q;
    end else if (pend_q && tick_q) begin
      pend_cnt_q <= pend_cnt_q - 16'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || st_q == S_OFF) begin
      sup_cnt_q <= 5'h00;
    end else if (btn_wake || btn_sd || emerg) begin
      sup_cnt_q <= SUPPRESS_LOAD;
    end else if (muted && tick_q) begin
      sup_cnt_q <= sup_cnt_q - 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      fb_cnt_q <= 16'h0000;
      fb_run_q <= 1'b0;
    end else if (st_d == S_FBS && st_q != S_FBS) begin
      fb_cnt_q <= fbtime_q;
      fb_run_q <= 1'b1;
    end else if (st_q != S_FBS || fb_exp) begin
      fb_run_q <= 1'b0;
    end else if (tick_q && fb_cnt_q != 16'h0000) begin
      fb_cnt_q <= fb_cnt_q - 16'h1;
    end
  end

  // ==========================================================
  // state machine
  logic [31:0] init_cnt_q;
  logic        tgt_lps_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_OFF: begin
        if (supply_w) st_d = S_INIT;
      end
      S_INIT: begin
        if (init_cnt_q >= INIT_CYCLES - 32'h1) st_d = S_SAVE;
      end
      S_SAVE: begin
        if (hib_done) st_d = S_LPS;
      end
      S_LPS: begin
        if (btn_wake || (pend_fire && pend_wake_q)) st_d = S_ON;
      end
      S_FBS: begin
        if (btn_wake || (pend_fire && pend_wake_q)) begin
          st_d = S_ON;
        end else if (pend_fire) begin
          st_d = S_SAVE;
        end
      end
      S_ON: begin
        if (emerg) begin
          st_d = S_LPS;
        end else if (btn_sd || exp_ev || (pend_fire && !pend_wake_q)) begin
          st_d = S_STOP;
        end
      end
      S_STOP: st_d = S_WREC;
      S_WREC: begin
        if (!recording_busy) st_d = S_WXFER;
      end
      S_WXFER: begin
        if (!transfer_busy) st_d = tgt_lps_q ? S_SAVE : S_FBS;
      end
      default: st_d = S_OFF;
    endcase
    if (!supply_w) st_d = S_OFF;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_q <= S_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || st_q != S_INIT) begin
      init_cnt_q <= 32'h0000_0000;
    end else begin
      init_cnt_q <= init_cnt_q + 32'h1;
    end
  end

  // where a shutdown sequence ends up
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tgt_lps_q <= 1'b1;
    end else if (st_q == S_ON && st_d == S_STOP) begin
      tgt_lps_q <= pend_fire ? pend_lps_q : sleep_lps;
    end
  end

  // ==========================================================
  // outputs
  logic [31:0] beep_cnt_q;
  osc_op_e     op_q;
  osc_pwr_s    pwr_q;
  logic        mstart_q;
  logic        mstop_q;
  logic        hib_q;
  logic        beep_q;
  logic        emerg_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      op_q     <= OP_OFF;
      pwr_q    <= '0;
      mstart_q <= 1'b0;
      mstop_q  <= 1'b0;
      hib_q    <= 1'b0;
      emerg_q  <= 1'b0;
    end else begin
      case (st_d)
        S_LPS, S_SAVE: op_q <= OP_LPS;
        S_FBS:         op_q <= OP_FBS;
        S_OFF, S_INIT: op_q <= OP_OFF;
        default:       op_q <= OP_ON;
      endcase
      pwr_q.pc_on       <= st_d >= S_ON || st_d == S_INIT;
      pwr_q.if_on       <= st_d >= S_ON;
      pwr_q.rec_ready   <= st_d == S_ON;
      pwr_q.wake_armed  <= st_d == S_LPS || st_d == S_FBS;
      pwr_q.sleep_armed <= st_d == S_FBS || st_d == S_ON;
      mstart_q <= st_d == S_ON && st_q != S_ON;
      mstop_q  <= st_d == S_STOP;
      hib_q    <= st_d == S_SAVE;
      emerg_q  <= st_q == S_ON && emerg;
    end
  end

  // acknowledge tone when initialisation is over
  always_ff @(posedge clock) begin
    if (!nrst || !supply_w) begin
      beep_q     <= 1'b0;
      beep_cnt_q <= 32'h0000_0000;
    end else if (st_q == S_INIT && st_d == S_SAVE) begin
      beep_q     <= 1'b1;
      beep_cnt_q <= 32'h0000_0000;
    end else if (beep_q) begin
      beep_cnt_q <= beep_cnt_q + 32'h1;
      if (beep_cnt_q >= BEEP_CYCLES - 32'h1) beep_q <= 1'b0;
    end
  end

  assign status_w = {22'h000000, fb_run_q, muted, pend_q, 1'b0, 4'(st_q), 2'(op_q)};

  assign reg_rdata     = rdata_q;
  assign op_state      = op_q;
  assign pwr           = pwr_q;
  assign meas_start    = mstart_q;
  assign meas_stop     = mstop_q;
  assign hib_save_req  = hib_q;
  assign ack_beep      = beep_q;
  assign emergency_off = emerg_q;

endmodule : osc_ctrl

//--- test/osc_ctrl_chk.sv
// osc_ctrl_chk: port assertions for the operating state controller
// assumes a bind onto osc_ctrl, one clock, synchronous active-low reset
`timescale 1ns/100ps

module osc_ctrl_chk
  import osc_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        supply_present,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input osc_op_e          op_state,
  input osc_pwr_s         pwr,
  input wire logic        meas_start,
  input wire logic        meas_stop,
  input wire logic        hib_save_req,
  input wire logic        emergency_off
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_enter_on;
    (op_state == OP_ON) && ($past(op_state) != OP_ON);
  endsequence
  // supply must be gone long enough for the sync pipe and state to follow
  sequence s_supply_gone;
    (!supply_present) [*4];
  endsequence
  sequence s_boot_save;
    (op_state == OP_LPS) && ($past(op_state) == OP_OFF);
  endsequence
  // ==========================================================
  // assertions
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_start_entry: assert property (s_enter_on |-> meas_start)
    else $error("no measurement start on entry to on");
  a_start_ready: assert property (meas_start |->
    (op_state == OP_ON && pwr.pc_on && pwr.if_on && pwr.rec_ready) ##1 !meas_start)
    else $error("start without full power");
  a_off_dark: assert property (s_supply_gone ##0 op_state == OP_OFF |-> pwr == '0)
    else $error("power outputs up while off");
  a_boot_save: assert property (s_boot_save |-> hib_save_req)
    else $error("first standby without image save");
  a_save_lps: assert property (hib_save_req |-> op_state == OP_LPS)
    else $error("image save outside low power standby");
  a_fbs_armed: assert property (op_state == OP_FBS |-> pwr.wake_armed && pwr.sleep_armed)
    else $error("fast boot standby not armed");
  a_emerg_lps: assert property (emergency_off |=> op_state == OP_LPS && !emergency_off)
    else $error("emergency off not to low power standby");
  a_stop_pulse: assert property (meas_stop |=> !meas_stop && !meas_start)
    else $error("stop pulse too long");
endmodule : osc_ctrl_chk

bind osc_ctrl osc_ctrl_chk i_chk (
  .clock         (clock),
  .nrst          (nrst),
  .supply_present (supply_present),
  .reg_rd        (reg_rd),
  .reg_rdata     (reg_rdata),
  .op_state      (op_state),
  .pwr           (pwr),
  .meas_start    (meas_start),
  .meas_stop     (meas_stop),
  .hib_save_req  (hib_save_req),
  .emergency_off (emergency_off)
);

//--- test/osc_src.sv
// osc_src: buttons, remote state pin and network activity source
// assumes the bench calls its tasks; all lines change after a rising edge
`timescale 1ns/100ps

module osc_src (
  input wire logic clock,
  output logic     button_n,
  output logic     remote_button_input_n,
  output logic     remote_power_state_input,
  output logic     network_activity_wake
);
  // ==========================================================
  // idle levels: buttons released, pin low, no activity
  initial begin
    button_n = 1'b1;
    remote_button_input_n = 1'b1;
    remote_power_state_input = 1'b0;
    network_activity_wake = 1'b0;
  end
  task automatic press(input bit remote, input int hold);
    @(posedge clock);
    if (remote) remote_button_input_n <= 1'b0;
    else button_n <= 1'b0;
    repeat (hold) @(posedge clock);
    remote_button_input_n <= 1'b1;
    button_n <= 1'b1;
  endtask : press
  task automatic pin(input logic v);
    @(posedge clock);
    remote_power_state_input <= v;
  endtask : pin
  // held 3 cycles so the synchroniser cannot miss it
  task automatic net_pulse();
    @(posedge clock);
    network_activity_wake <= 1'b1;
    repeat (3) @(posedge clock);
    network_activity_wake <= 1'b0;
  endtask : net_pulse
endmodule : osc_src

//--- test/tb.sv
// tb: scenarios for the operating state controller
// assumes shortened second, press, debounce, init and beep counts
`timescale 1ns/100ps

module tb;
  import osc_pkg::*;
  logic        clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, current_time = 32'h0;
  logic        supply_present = 1'b0, meas_done = 1'b0, tasks_pending = 1'b0;
  logic        exp_shutdown = 1'b0, recording_busy = 1'b0, transfer_busy = 1'b0;
  logic        hib_done = 1'b0;
  logic [31:0] reg_rdata;
  osc_op_e     op_state;
  osc_pwr_s    pwr;
  logic        meas_start, meas_stop, hib_save_req, ack_beep, emergency_off;
  logic        button_n, remote_button_input_n, remote_power_state_input;
  logic        network_activity_wake;
  int          fail_count = 0, compares = 0;
  always #2.5 clock = ~clock;
  osc_src i_src (
    .clock                    (clock),
    .button_n                 (button_n),
    .remote_button_input_n    (remote_button_input_n),
    .remote_power_state_input (remote_power_state_input),
    .network_activity_wake    (network_activity_wake)
  );
  osc_ctrl #(
    .SEC_CYCLES(32'd20), .LONG_CYCLES(32'd200), .DEB_CYCLES(32'd4),
    .INIT_CYCLES(32'd10), .BEEP_CYCLES(32'd5)
  ) i_dut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_present(supply_present), .button_n(button_n),
    .remote_button_input_n(remote_button_input_n),
    .remote_power_state_input(remote_power_state_input),
    .network_activity_wake(network_activity_wake), .current_time(current_time),
    .meas_done(meas_done), .tasks_pending(tasks_pending), .exp_shutdown(exp_shutdown),
    .recording_busy(recording_busy), .transfer_busy(transfer_busy),
    .hib_done(hib_done), .op_state(op_state), .pwr(pwr), .meas_start(meas_start),
    .meas_stop(meas_stop), .hib_save_req(hib_save_req), .ack_beep(ack_beep),
    .emergency_off(emergency_off)
  );
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask : rd_chk
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  // k: 0 on, 1 settled lps, 2 fbs, 3 save, 4 stop, 5 emergency
  task automatic wait_for(input int k, input int n);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      idle(1);
      case (k)
        0: hit = (op_state === OP_ON);
        1: hit = (op_state === OP_LPS) && (hib_save_req === 1'b0);
        2: hit = (op_state === OP_FBS);
        3: hit = (hib_save_req === 1'b1);
        4: hit = (meas_stop === 1'b1);
        default: hit = (emergency_off === 1'b1);
      endcase
    end
    chk($sformatf("wait %0d", k), 1, hit);
    if (!hit) tally_and_finish();
  endtask : wait_for
  task automatic save_done(input int n);
    wait_for(3, n);
    hib_done <= 1'b1;
    idle(1);
    hib_done <= 1'b0;
    wait_for(1, 20);
  endtask : save_done
  // ==========================================================
  // scenarios
  task automatic t_regs();
    idle(1);
    chk("off state", OP_OFF, op_state);
    chk("off power", 0, pwr);
    rd_chk(OFS_CTRL, CTRL_RST);
    rd_chk(OFS_DELAY, DELAY_RST);
    rd_chk(OFS_FBTIME, FBTIME_RST);
    rd_chk(OFS_START, TIME_RST);
    rd_chk(OFS_END, TIME_RST);
    wr(8'h18, 32'hffff_ffff);
    rd_chk(8'h18, 0);
    wr(OFS_DELAY, 32'h0001_0003);
    rd_chk(OFS_DELAY, 32'h0000_0003);
    wr(OFS_DELAY, 0);
    $display("done regs");
  endtask : t_regs
  task automatic t_boot();
    supply_present <= 1'b1;
    wait_for(3, 100);
    chk("beep", 1, ack_beep);
    save_done(10);
    $display("done boot");
  endtask : t_boot
  task automatic t_btn();
    recording_busy <= 1'b1;
    transfer_busy <= 1'b1;
    i_src.press(1'b0, 10);
    wait_for(0, 30);
    chk("on power", 1, pwr.pc_on & pwr.if_on & pwr.rec_ready);
    i_src.press(1'b0, 10);
    wait_for(4, 30);
    idle(20);
    chk("wait rec", 0, hib_save_req);
    recording_busy <= 1'b0;
    idle(20);
    chk("wait xfer", 0, hib_save_req);
    transfer_busy <= 1'b0;
    save_done(20);
    $display("done button");
  endtask : t_btn
  task automatic t_pin();
    i_src.pin(1'b1);
    idle(100);
    chk("muted", OP_LPS, op_state);
    idle(400);
    i_src.pin(1'b0);
    idle(20);
    i_src.pin(1'b1);
    wait_for(0, 60);
    i_src.pin(1'b0);
    wait_for(4, 60);
    save_done(40);
    $display("done pin");
  endtask : t_pin
  task automatic t_net();
    wr(OFS_CTRL, 32'h0000_01f7);
    i_src.net_pulse();
    idle(60);
    chk("net disabled", OP_LPS, op_state);
    wr(OFS_CTRL, 32'h0000_01ff);
    wr(OFS_DELAY, 32'h0000_0002);
    i_src.net_pulse();
    idle(15);
    chk("delayed", OP_LPS, op_state);
    wait_for(0, 100);
    $display("done net");
  endtask : t_net
  task automatic t_auto();
    wr(OFS_DELAY, 0);
    wr(OFS_FBTIME, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_05ff);
    tasks_pending <= 1'b1;
    meas_done <= 1'b1;
    idle(1);
    meas_done <= 1'b0;
    idle(40);
    chk("pending", OP_ON, op_state);
    tasks_pending <= 1'b0;
    meas_done <= 1'b1;
    idle(1);
    meas_done <= 1'b0;
    wait_for(2, 100);
    save_done(200);
    $display("done auto");
  endtask : t_auto
  task automatic t_emerg();
    i_src.press(1'b1, 10);
    wait_for(0, 30);
    fork
      i_src.press(1'b1, 260);
      wait_for(5, 250);
    join
    idle(50);
    chk("no short", OP_LPS, op_state);
    $display("done emergency");
  endtask : t_emerg
  // idle long enough for the button hold-off to run out first
  task automatic t_time();
    wr(OFS_START, 32'h0000_0100);
    wr(OFS_END, 32'h0000_0200);
    idle(300);
    current_time <= 32'h0000_0100;
    wait_for(0, 20);
    current_time <= 32'h0000_0200;
    wait_for(4, 20);
    save_done(20);
    current_time <= 32'h0000_0100;
    wait_for(0, 20);
    wr(OFS_DELAY, 32'h0000_0005);
    exp_shutdown <= 1'b1;
    wait_for(4, 4);
    exp_shutdown <= 1'b0;
    save_done(20);
    supply_present <= 1'b0;
    idle(5);
    chk("supply off", OP_OFF, op_state);
    chk("dark", 0, pwr);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rd_chk(OFS_START, TIME_RST);
    supply_present <= 1'b1;
    wait_for(3, 100);
    $display("done time");
  endtask : t_time
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_boot();
    t_btn();
    t_pin();
    t_net();
    t_auto();
    t_emerg();
    t_time();
    tally_and_finish();
  end
endmodule : tb
